// >>> csc_pkg.sv
package csc_pkg;

	// ------------------------------------------------------------
	// Build options
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CSC_ARCH_SEQ = 2'h1,
		CSC_ARCH_PAR = 2'h2
	} csc_arch_t;

	typedef enum logic [3:0]
	{
		CSC_CUSTOM          = 4'h0,
		CSC_CRGB_TO_SDYCC   = 4'h1,
		CSC_CRGB_TO_HDYCC   = 4'h2,
		CSC_SRGB_TO_SDYCC   = 4'h3,
		CSC_SRGB_TO_HDYCC   = 4'h4,
		CSC_SDYCC_TO_CRGB   = 4'h5,
		CSC_HDYCC_TO_CRGB   = 4'h6,
		CSC_SDYCC_TO_SRGB   = 4'h7,
		CSC_HDYCC_TO_SRGB   = 4'h8,
		CSC_YUV_TO_CRGB     = 4'h9,
		CSC_CRGB_TO_YUV     = 4'ha,
		CSC_YIQ_TO_CRGB     = 4'hb,
		CSC_CRGB_TO_YIQ     = 4'hc
	} csc_type_t;

	// ------------------------------------------------------------
	// Defaults
	// ------------------------------------------------------------
	localparam csc_arch_t DEF_ARCH      = CSC_ARCH_SEQ;
	localparam csc_type_t DEF_TYPE      = CSC_CRGB_TO_SDYCC;
	localparam int        DEF_IN_W      = 8;
	localparam int        DEF_COEF_W    = 18;
	localparam bit        DEF_SIGNED    = 1'b0;
	localparam bit        DEF_REG_IN    = 1'b1;
	localparam bit        DEF_HAS_CE    = 1'b0;
	localparam bit        DEF_HAS_SR    = 1'b0;
	localparam int        COEF_FRAC     = 14;
	localparam int        MULT_STAGES   = 2;
	localparam int        NUM_PLANES    = 3;

	// Coefficients in Q.14 at full width, row-major c[out][in]
	typedef logic signed [17:0] csc_coef_t [9];
	typedef logic signed [17:0] csc_off_t [3];

	function automatic csc_coef_t csc_coefs(csc_type_t t);
		csc_coef_t c;
		c = '{default: 18'sh0_0000};
		unique case (t)
			CSC_CRGB_TO_SDYCC, CSC_SRGB_TO_SDYCC:
				c = '{18'sh0_1323, 18'sh0_2591, 18'sh0_074c,
				      -18'sh0_0ad0, -18'sh0_1530, 18'sh0_2000,
				      18'sh0_2000, -18'sh0_1acf, -18'sh0_0531};
			CSC_CRGB_TO_HDYCC, CSC_SRGB_TO_HDYCC:
				c = '{18'sh0_0d9b, 18'sh0_2dc6, 18'sh0_049f,
				      -18'sh0_0753, -18'sh0_18ad, 18'sh0_2000,
				      18'sh0_2000, -18'sh0_1d16, -18'sh0_02ea};
			CSC_SDYCC_TO_CRGB, CSC_SDYCC_TO_SRGB:
				c = '{18'sh0_4000, 18'sh0_0000, 18'sh0_59ba,
				      18'sh0_4000, -18'sh0_1604, -18'sh0_2db6,
				      18'sh0_4000, 18'sh0_7168, 18'sh0_0000};
			CSC_HDYCC_TO_CRGB, CSC_HDYCC_TO_SRGB:
				c = '{18'sh0_4000, 18'sh0_0000, 18'sh0_64d0,
				      18'sh0_4000, -18'sh0_0bfc, -18'sh0_1de0,
				      18'sh0_4000, 18'sh0_76c3, 18'sh0_0000};
			CSC_YUV_TO_CRGB:
				c = '{18'sh0_4000, 18'sh0_0000, 18'sh0_48f6,
				      18'sh0_4000, -18'sh0_1953, -18'sh0_2524,
				      18'sh0_4000, 18'sh0_8208, 18'sh0_0000};
			CSC_CRGB_TO_YUV:
				c = '{18'sh0_1323, 18'sh0_2591, 18'sh0_074c,
				      -18'sh0_0958, -18'sh0_124d, 18'sh0_1ba5,
				      18'sh0_2762, -18'sh0_20ee, -18'sh0_0674};
			CSC_YIQ_TO_CRGB:
				c = '{18'sh0_4000, 18'sh0_3d2f, 18'sh0_27e6,
				      18'sh0_4000, -18'sh0_1169, -18'sh0_2995,
				      18'sh0_4000, -18'sh0_46c8, 18'sh0_6cea};
			CSC_CRGB_TO_YIQ:
				c = '{18'sh0_1323, 18'sh0_2591, 18'sh0_074c,
				      18'sh0_2626, -18'sh0_1199, -18'sh0_148d,
				      18'sh0_0d89, -18'sh0_2187, 18'sh0_13fe};
			default:
				c = '{default: 18'sh0_0000};
		endcase
		return c;
	endfunction

	// Offsets in input-sample units, scaled to the 8-bit range
	function automatic csc_off_t csc_offs(csc_type_t t);
		csc_off_t o;
		o = '{default: 18'sh0_0000};
		unique case (t)
			CSC_CRGB_TO_SDYCC, CSC_CRGB_TO_HDYCC,
			CSC_SRGB_TO_SDYCC, CSC_SRGB_TO_HDYCC:
				o = '{18'sh0_0000, 18'sh0_0080, 18'sh0_0080};
			CSC_SDYCC_TO_CRGB, CSC_SDYCC_TO_SRGB:
				o = '{-18'sh0_00b3, 18'sh0_0088, -18'sh0_00e3};
			CSC_HDYCC_TO_CRGB, CSC_HDYCC_TO_SRGB:
				o = '{-18'sh0_00c9, 18'sh0_0053, -18'sh0_00ed};
			default:
				o = '{default: 18'sh0_0000};
		endcase
		return o;
	endfunction

endpackage

// >>> csc_if.sv
`timescale 1ns/10ps
interface csc_if #(
	parameter int IN_W  = 8,
	parameter int OUT_W = 8
);
	logic             in_valid;
	logic [IN_W-1:0]  plane_in_a;
	logic [IN_W-1:0]  plane_in_b;
	logic [IN_W-1:0]  plane_in_c;
	logic             out_valid;
	logic [OUT_W-1:0] plane_out_a;
	logic [OUT_W-1:0] plane_out_b;
	logic [OUT_W-1:0] plane_out_c;

	modport dev
	(
		input  in_valid, plane_in_a, plane_in_b, plane_in_c,
		output out_valid, plane_out_a, plane_out_b, plane_out_c
	);

	modport host
	(
		output in_valid, plane_in_a, plane_in_b, plane_in_c,
		input  out_valid, plane_out_a, plane_out_b, plane_out_c
	);
endinterface

// >>> csc_core.sv
// How it works
// - Parallel: upstream gives three planes together.
// - Parallel: upstream strobes valid with each set.
// - Parallel: three outputs together after fixed latency.
// - Sequential: three planes over one input port.
// - Sequential: valid with first plane, two follow.
// - Sequential: outputs first plane valid, two follow.
// - Custom or predefined transform; default RGB-to-SDTV.
// - Architecture build choice; sequential by default.
// - Inputs signed or unsigned; unsigned default.
// - Input width 8/10/12/16; default eight.
// - Coefficient precision 9 to 18; default 18.
// - Inputs registered by default; removable.
// - Sequential: valid low on planes two, three.
// - Sequential: output valid low on later planes.
// - Clock enable low freezes all state.
// - Sync reset clears registers, output valid low.
`timescale 1ns/10ps
module csc_core
	import csc_pkg::*;
#(
	parameter csc_arch_t ARCH    = DEF_ARCH,
	parameter csc_type_t TYPE    = DEF_TYPE,
	parameter int        IN_W    = DEF_IN_W,
	parameter int        COEF_W  = DEF_COEF_W,
	parameter bit        IN_SIGN = DEF_SIGNED,
	parameter bit        REG_IN  = DEF_REG_IN,
	parameter bit        HAS_CE  = DEF_HAS_CE,
	parameter bit        HAS_SR  = DEF_HAS_SR,
	parameter csc_coef_t CUST_C  = '{default: 18'sh0_0000},
	parameter csc_off_t  CUST_O  = '{default: 18'sh0_0000}
)
(
	// Clock and controls
	input  wire logic clk,
	input  wire logic ce,
	input  wire logic sync_reset_in,
	// Stream
	csc_if.dev        port
);

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam int AW  = IN_W + 2;
	localparam int PW  = AW + COEF_W;
	localparam int SW  = PW + 3;
	localparam int SH  = COEF_FRAC - (18 - COEF_W);
	localparam int IN_STG  = REG_IN ? 1 : 0;
	localparam csc_coef_t CF = (TYPE == CSC_CUSTOM) ? CUST_C : csc_coefs(TYPE);
	localparam csc_off_t  OF = (TYPE == CSC_CUSTOM) ? CUST_O : csc_offs(TYPE);
	localparam logic [SW-1:0] OMAX = SW'((1 << IN_W) - 1);

	// Enables: an absent clock enable is tied high, an absent reset low
	logic en;
	logic clr;
	assign en  = HAS_CE ? ce : 1'b1;
	assign clr = HAS_SR ? sync_reset_in : 1'b0;

	// ------------------------------------------------------------
	// Input capture
	// ------------------------------------------------------------
	logic [IN_W-1:0] rin [3];
	logic            rvld;
	logic [IN_W-1:0] next_rin [3];
	logic            next_rvld;
	logic [IN_W-1:0] xin [3];
	logic            xvld;

	always_comb
	begin
		next_rin[0] = port.plane_in_a;
		next_rin[1] = port.plane_in_b;
		next_rin[2] = port.plane_in_c;
		next_rvld   = port.in_valid;
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			rin  <= '{default: '0};
			rvld <= 1'b0;
		end
		else if (en)
		begin
			rin  <= next_rin;
			rvld <= next_rvld;
		end
	end

	// Bypassing trades input setup margin for one cycle less latency
	assign xin  = REG_IN ? rin : next_rin;
	assign xvld = REG_IN ? rvld : next_rvld;

	// ------------------------------------------------------------
	// Sequential deserialiser
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		CSC_S_IDLE = 3'h1,
		CSC_S_P2   = 3'h2,
		CSC_S_P3   = 3'h4
	} csc_seq_t;

	csc_seq_t        st;
	csc_seq_t        next_st;
	logic [IN_W-1:0] hold [2];
	logic [IN_W-1:0] next_hold [2];
	logic [IN_W-1:0] opnd [3];
	logic            ovld;

	always_comb
	begin
		next_st   = st;
		next_hold = hold;
		unique case (st)
			CSC_S_IDLE:
				if (xvld)
				begin
					next_hold[0] = xin[0];
					next_st      = CSC_S_P2;
				end
			CSC_S_P2:
			begin
				next_hold[1] = xin[0];
				next_st      = CSC_S_P3;
			end
			CSC_S_P3:
				next_st = CSC_S_IDLE;
			default:
				next_st = CSC_S_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			st   <= CSC_S_IDLE;
			hold <= '{default: '0};
		end
		else if (en)
		begin
			st   <= next_st;
			hold <= next_hold;
		end
	end

	always_comb
	begin
		if (ARCH == CSC_ARCH_SEQ)
		begin
			opnd[0] = hold[0];
			opnd[1] = hold[1];
			opnd[2] = xin[0];
			ovld    = (st == CSC_S_P3);
		end
		else
		begin
			opnd = xin;
			ovld = xvld;
		end
	end

	// ------------------------------------------------------------
	// Multiply stage then sum stage, fixed depth
	// ------------------------------------------------------------
	logic signed [PW-1:0] prod [9];
	logic signed [PW-1:0] next_prod [9];
	logic signed [SW-1:0] acc [3];
	logic signed [SW-1:0] next_acc [3];
	logic [MULT_STAGES-1:0] vpipe;
	logic [MULT_STAGES-1:0] next_vpipe;

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++)
		begin : g_mul
			logic signed [AW-1:0]     a;
			logic signed [COEF_W-1:0] k;
			// Coefficients trimmed to the chosen precision
			assign k = COEF_W'(CF[gi] >>> (18 - COEF_W));
			assign a = IN_SIGN
				? AW'(signed'(opnd[gi % 3]))
				: AW'(signed'({1'b0, opnd[gi % 3]}));
			// Widen first so the product keeps every bit
			assign next_prod[gi] = PW'(a) * PW'(k);
		end
		for (gi = 0; gi < 3; gi++)
		begin : g_sum
			logic signed [SW-1:0] off;
			assign off = SW'(signed'(OF[gi])) <<< SH;
			assign next_acc[gi] = SW'(prod[3*gi]) + SW'(prod[3*gi+1])
				+ SW'(prod[3*gi+2]) + off;
		end
	endgenerate

	assign next_vpipe = {vpipe[MULT_STAGES-2:0], ovld};

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			prod  <= '{default: '0};
			acc   <= '{default: '0};
			vpipe <= '0;
		end
		else if (en)
		begin
			prod  <= next_prod;
			acc   <= next_acc;
			vpipe <= next_vpipe;
		end
	end

	// ------------------------------------------------------------
	// Output: scale, saturate, serialise
	// ------------------------------------------------------------
	logic [IN_W-1:0] res [3];
	logic [IN_W-1:0] oreg [3];
	logic [IN_W-1:0] next_oreg [3];
	logic            oval;
	logic            next_oval;
	logic [1:0]      ocnt;
	logic [1:0]      next_ocnt;
	logic            done;

	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sat
			logic signed [SW-1:0] sc;
			assign sc = acc[gi] >>> SH;
			// Clip to the sample range instead of wrapping
			assign res[gi] = sc[SW-1] ? '0
				: (sc > signed'(OMAX)) ? IN_W'(OMAX) : sc[IN_W-1:0];
		end
	endgenerate

	assign done = vpipe[MULT_STAGES-1];

	always_comb
	begin
		next_oreg = oreg;
		next_ocnt = '0;
		next_oval = 1'b0;
		if (ARCH == CSC_ARCH_PAR)
		begin
			next_oval = done;
			if (done)
				next_oreg = res;
		end
		else if (done)
		begin
			next_oreg = res;
			next_oval = 1'b1;
			next_ocnt = 2'h1;
		end
		else if (ocnt != 2'h0)
		begin
			// Shift next plane to the single port
			next_oreg[0] = oreg[1];
			next_oreg[1] = oreg[2];
			next_ocnt    = (ocnt == 2'h2) ? 2'h0 : 2'h2;
			next_oval    = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			oreg <= '{default: '0};
			oval <= 1'b0;
			ocnt <= '0;
		end
		else if (en)
		begin
			oreg <= next_oreg;
			oval <= next_oval;
			ocnt <= next_ocnt;
		end
	end

	assign port.out_valid   = oval;
	assign port.plane_out_a = oreg[0];
	assign port.plane_out_b = (ARCH == CSC_ARCH_PAR) ? oreg[1] : '0;
	assign port.plane_out_c = (ARCH == CSC_ARCH_PAR) ? oreg[2] : '0;

endmodule

// >>> csc_src.sv
`timescale 1ns/10ps
module csc_src
	import csc_pkg::*;
#(
	parameter csc_arch_t ARCH = DEF_ARCH,
	parameter int        IN_W = DEF_IN_W
)
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// User side
	input  wire logic            usr_valid,
	output logic                 usr_ready,
	input  wire logic [IN_W-1:0] usr_a,
	input  wire logic [IN_W-1:0] usr_b,
	input  wire logic [IN_W-1:0] usr_c,
	// Stream
	csc_if.host                  port
);

	// ------------------------------------------------------------
	// Plane sequencer
	// ------------------------------------------------------------
	logic [1:0]      cnt;
	logic [1:0]      next_cnt;
	logic [IN_W-1:0] dat [3];
	logic [IN_W-1:0] next_dat [3];
	logic            vld;
	logic            next_vld;

	// Sequential build takes a new set only every third cycle
	assign usr_ready = (ARCH == CSC_ARCH_PAR) || (cnt == 2'h0);

	always_comb
	begin
		next_cnt = 2'h0;
		next_dat = dat;
		next_vld = 1'b0;
		if (ARCH == CSC_ARCH_PAR)
		begin
			next_dat = '{usr_a, usr_b, usr_c};
			next_vld = usr_valid;
		end
		else if (cnt == 2'h0)
		begin
			if (usr_valid)
			begin
				next_dat = '{usr_a, usr_b, usr_c};
				next_vld = 1'b1;
				next_cnt = 2'h1;
			end
		end
		else
		begin
			// No gap between planes, valid stays low
			next_dat[0] = dat[1];
			next_dat[1] = dat[2];
			next_cnt    = (cnt == 2'h1) ? 2'h2 : 2'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= '0;
			dat <= '{default: '0};
			vld <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			dat <= next_dat;
			vld <= next_vld;
		end
	end

	assign port.in_valid   = vld;
	assign port.plane_in_a = dat[0];
	assign port.plane_in_b = (ARCH == CSC_ARCH_PAR) ? dat[1] : '0;
	assign port.plane_in_c = (ARCH == CSC_ARCH_PAR) ? dat[2] : '0;

endmodule

// >>> csc_props.sv
`timescale 1ns/10ps
module csc_props
#(
	parameter int IN_W  = 8,
	parameter int OUT_W = 8
)
(
	// Clock and resets
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             ce,
	input wire logic             sync_reset_in,
	// Stream
	input wire logic             in_valid,
	input wire logic [IN_W-1:0]  plane_in_a,
	input wire logic [IN_W-1:0]  plane_in_b,
	input wire logic [IN_W-1:0]  plane_in_c,
	input wire logic             out_valid,
	input wire logic [OUT_W-1:0] plane_out_a,
	input wire logic [OUT_W-1:0] plane_out_b,
	input wire logic [OUT_W-1:0] plane_out_c
);
	// ------------------------------------------------------------
	// Enabled-edge history of input valid
	// ------------------------------------------------------------
	// Counts only enabled edges, so a frozen pipeline keeps its place
	logic [5:0] hist;
	logic [5:0] next_hist;

	always_comb
	begin
		next_hist = hist;
		if (sync_reset_in)
			next_hist = '0;
		else if (ce)
			next_hist = {hist[4:0], in_valid};
	end

	always_ff @(posedge clk)
	begin
		hist <= next_hist;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sync_reset_in);

	sequence s_lead;
		out_valid && ce;
	endsequence

	sequence s_first;
		in_valid;
	endsequence

	a_valid_latency : assert property (out_valid == hist[5])
		else $error("output valid not six enabled cycles after input");
	a_out_gap : assert property (s_lead ##1 ce |-> !out_valid)
		else $error("output valid high on a later plane");
	a_in_gap : assert property (s_first |=> !in_valid [*2])
		else $error("input valid high on a later plane");
	a_frozen_state : assert property (disable iff (sync_reset_in)
		!ce |=> $stable(out_valid) && $stable(plane_out_a))
		else $error("outputs moved while clock enable low");
	a_reset_clear : assert property (disable iff (1'b0)
		sync_reset_in |=> !out_valid && plane_out_a == '0)
		else $error("outputs not cleared by synchronous reset");
	a_in_single : assert property (plane_in_b == '0 && plane_in_c == '0)
		else $error("second or third input port used");
	a_out_single : assert property (plane_out_b == '0 && plane_out_c == '0)
		else $error("second or third output port used");
	a_src_quiet : assert property (disable iff (1'b0) rst |=> !in_valid)
		else $error("input valid high after source reset");
endmodule

// >>> tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) \
		begin \
			n_mismatch++; \
			$display("mismatch %s exp %h got %h", nm, ex, got); \
		end \
	end

module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk           = 1'b0;
	logic        rst           = 1'b1;
	logic        ce            = 1'b1;
	logic        sync_reset_in = 1'b1;
	logic        usr_valid     = 1'b0;
	logic        usr_valid_p   = 1'b0;
	logic        usr_ready;
	logic        usr_ready_p;
	logic [7:0]  usr_a         = 8'h00;
	logic [7:0]  usr_b         = 8'h00;
	logic [7:0]  usr_c         = 8'h00;
	logic        ce_q          = 1'b1;
	logic [7:0]  q[$];
	logic [23:0] qp[$];
	logic [7:0]  e;
	logic [23:0] ep;
	int          n_mismatch    = 0;
	int          tests_run     = 0;
	int          seed          = 24341;
	int          cyc           = 0;
	int          phase         = 0;

	always #4 clk = ~clk;

	csc_if #(.IN_W(8), .OUT_W(8)) bus ();

	csc_core #(.HAS_CE(1'b1), .HAS_SR(1'b1)) i_csc_core
	(
		.clk           (clk),
		.ce            (ce),
		.sync_reset_in (sync_reset_in),
		.port          (bus)
	);

	csc_src i_csc_src
	(
		.clk       (clk),
		.rst       (rst),
		.usr_valid (usr_valid),
		.usr_ready (usr_ready),
		.usr_a     (usr_a),
		.usr_b     (usr_b),
		.usr_c     (usr_c),
		.port      (bus)
	);

	csc_if #(.IN_W(8), .OUT_W(8)) bus_p ();

	// Parallel pair, own scope so instance names can repeat
	if (1'b1)
	begin : g_par
		csc_core #(
			.ARCH   (csc_pkg::CSC_ARCH_PAR),
			.HAS_CE (1'b1),
			.HAS_SR (1'b1)
		) i_csc_core
		(
			.clk           (clk),
			.ce            (ce),
			.sync_reset_in (sync_reset_in),
			.port          (bus_p)
		);

		csc_src #(.ARCH(csc_pkg::CSC_ARCH_PAR)) i_csc_src
		(
			.clk       (clk),
			.rst       (rst),
			.usr_valid (usr_valid_p),
			.usr_ready (usr_ready_p),
			.usr_a     (usr_a),
			.usr_b     (usr_b),
			.usr_c     (usr_c),
			.port      (bus_p)
		);
	end

	csc_props i_csc_props
	(
		.clk (clk), .rst (rst), .ce (ce), .sync_reset_in (sync_reset_in),
		.in_valid (bus.in_valid), .plane_in_a (bus.plane_in_a),
		.plane_in_b (bus.plane_in_b), .plane_in_c (bus.plane_in_c),
		.out_valid (bus.out_valid), .plane_out_a (bus.plane_out_a),
		.plane_out_b (bus.plane_out_b), .plane_out_c (bus.plane_out_c)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Fixed point weighted sum, floor shift, clipped to eight bits
	function automatic logic [7:0] pl(int x, int y, int z,
		int cx, int cy, int cz, int off);
		int v;
		v = (cx * x + cy * y + cz * z + (off <<< 14)) >>> 14;
		return (v < 0) ? 8'h00 : ((v > 255) ? 8'hff : 8'(v));
	endfunction

	// All three planes of one set, first plane on top
	function automatic logic [23:0] exp3(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		return {pl(a, b, c, 4899, 9617, 1868, 0),
			pl(a, b, c, -2768, -5424, 8192, 128),
			pl(a, b, c, 8192, -6863, -1329, 128)};
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Leaves valid high so back-to-back sends need no gap
	task automatic send(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		int i;
		q.push_back(pl(a, b, c, 4899, 9617, 1868, 0));
		q.push_back(pl(a, b, c, -2768, -5424, 8192, 128));
		q.push_back(pl(a, b, c, 8192, -6863, -1329, 128));
		usr_valid <= 1'b1;
		usr_a <= a;
		usr_b <= b;
		usr_c <= c;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (usr_ready !== 1'b1 && i < 8);
		`CHK("usr_ready", 1'b1, usr_ready)
	endtask

	// Parallel build takes a set on every cycle
	task automatic send_p(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		qp.push_back(exp3(a, b, c));
		usr_valid_p <= 1'b1;
		usr_a <= a;
		usr_b <= b;
		usr_c <= c;
		@(posedge clk);
		`CHK("usr_ready_p", 1'b1, usr_ready_p)
	endtask

	task automatic idle(input int n);
		usr_valid <= 1'b0;
		usr_valid_p <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic do_reset(input int n);
		rst <= 1'b1;
		sync_reset_in <= 1'b1;
		usr_valid <= 1'b0;
		usr_valid_p <= 1'b0;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		sync_reset_in <= 1'b0;
		q.delete();
		phase = 0;
	endtask

	// ------------------------------------------------------------
	// Output watcher
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (!rst && ce_q)
		begin
			if (bus.out_valid === 1'b1)
				phase = 1;
			if (phase > 0)
			begin
				e = (q.size() > 0) ? q.pop_front() : 8'hxx;
				`CHK("plane_out_a", e, bus.plane_out_a)
				phase = (phase == 3) ? 0 : phase + 1;
			end
		end
		ce_q <= ce;
	end

	// A stray parallel result counts as a mismatch against an unknown, a missing one stays in qp
	always @(posedge clk)
	begin
		if (!rst && ce_q && bus_p.out_valid === 1'b1)
		begin
			ep = (qp.size() > 0) ? qp.pop_front() : 24'hxx_xxxx;
			`CHK("plane_out_a_p", ep[23:16], bus_p.plane_out_a)
			`CHK("plane_out_b_p", ep[15:8], bus_p.plane_out_b)
			`CHK("plane_out_c_p", ep[7:0], bus_p.plane_out_c)
		end
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		do_reset(4);
		// Extremes back to back
		send(8'h00, 8'h00, 8'h00);
		send(8'hff, 8'hff, 8'hff);
		send(8'hff, 8'h00, 8'h00);
		send(8'h00, 8'h00, 8'hff);
		idle(12);
		repeat (20) send(8'($random(seed)), 8'($random(seed)),
			8'($random(seed)));
		idle(12);
		// Freeze with data in the pipeline
		send(8'h40, 8'h80, 8'hc0);
		idle(4);
		ce <= 1'b0;
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		idle(12);
		`CHK("queue", 32'd0, 32'(q.size()))
		// Parallel build, a fresh set on every cycle
		repeat (20) send_p(8'($random(seed)), 8'($random(seed)),
			8'($random(seed)));
		idle(8);
		`CHK("queue_p", 32'd0, 32'(qp.size()))
		// Reset with data in flight drops it
		send(8'h10, 8'h20, 8'h30);
		idle(3);
		do_reset(1);
		// Only the set sent after reset may come out
		send(8'h10, 8'h20, 8'h30);
		idle(14);
		`CHK("queue", 32'd0, 32'(q.size()))
		conclude();
	end
endmodule
